// file: rtl/uee_ctrl.sv
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "uee_defs.svh"
module uee_ctrl (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // axi4-lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // role and link engine events
  input  wire logic        host_role,
  input  wire logic        ev_stuffing_error,
  input  wire logic        ev_buffer_overrun,
  input  wire logic        ev_turnaround_timeout,
  input  wire logic        ev_partial_byte,
  input  wire logic        ev_data_checksum_fail,
  input  wire logic        ev_token_checksum_fail,
  input  wire logic        ev_frame_end_error,
  input  wire logic        ev_packet_id_fail,
  input  wire logic        ep_stall_event,
  input  wire logic [3:0]  ep_stall_num,
  // receive byte truncation
  input  wire logic [9:0]  rx_byte_index,
  input  wire logic [9:0]  bd_byte_count,
  output logic             rx_byte_store,
  // endpoint query from token engine
  input  wire logic [3:0]  tok_ep,
  output logic             tok_rx_allowed,
  output logic             tok_tx_allowed,
  output logic             tok_setup_allowed,
  output logic             tok_handshake_en,
  output logic             low_speed_direct,
  output logic             nak_retry_disable,
  // status and pwm
  output logic             usb_error_summary_flag,
  output logic             vbus_pwm_out,
  output logic [15:0]      vbus_pwm_count,
  input  wire logic [15:0] vbus_pwm_duty
);
  uee_pkg::uee_state_s q, d;
  logic [7:0]  ep_sel;
  logic [7:0]  err_set;
  logic [7:0]  ep_rd;
  logic        wr_go;
  logic        rd_go;
  logic [11:0] wa;
  logic [31:0] wd;
  logic [15:0] rd16;
  logic        rd_ok;
  logic        cnt_run;

  function automatic logic [7:0] ep_view(input logic [3:0] n,
                                         input logic [7:0] v,
                                         input logic       host);
    logic [7:0] m;
    m = `UEE_EP_MASK;
    if (!(n == 4'h0 && host)) begin
      m = m & ~`UEE_EP_HOST0_MASK;
    end
    ep_view = v & m;
  endfunction

  always_comb begin
    err_set = 8'h00;
    err_set[7] = ev_stuffing_error;
    err_set[5] = ev_buffer_overrun;
    err_set[4] = ev_turnaround_timeout;
    err_set[3] = ev_partial_byte;
    err_set[2] = ev_data_checksum_fail;
    err_set[1] = host_role ? ev_frame_end_error
                           : ev_token_checksum_fail;
    err_set[0] = ev_packet_id_fail;
  end

  // no aw, w or ar ready while frozen, else a taken item would be lost
  assign s_axi_awready = clk_en && !q.aw_got && !q.bvalid;
  assign s_axi_wready  = clk_en && !q.w_got && !q.bvalid;
  assign s_axi_arready = clk_en && !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign wa = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : q.awaddr;
  assign wd = s_axi_wvalid && s_axi_wready ? s_axi_wdata : q.wdata;
  assign wr_go = (q.aw_got || (s_axi_awvalid && s_axi_awready))
              && (q.w_got || (s_axi_wvalid && s_axi_wready));
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_comb begin
    ep_sel = ep_view(tok_ep, q.ep[tok_ep], host_role);
    tok_rx_allowed  = ep_sel[`UEE_EP_RX_EN];
    tok_tx_allowed  = ep_sel[`UEE_EP_TX_EN];
    // setup needs both directions; block bit only counts then
    tok_setup_allowed = ep_sel[`UEE_EP_RX_EN] && ep_sel[`UEE_EP_TX_EN]
                     && !ep_sel[`UEE_EP_SETUP_BLK];
    tok_handshake_en = ep_sel[`UEE_EP_HSHK];
  end

  assign low_speed_direct  = host_role && q.ep[0][`UEE_EP_LOW_SPEED_DIRECT];
  assign nak_retry_disable = host_role && q.ep[0][`UEE_EP_RETRY_DIS];
  // bytes past the descriptor count are dropped
  assign rx_byte_store = rx_byte_index < bd_byte_count;
  assign usb_error_summary_flag = q.summary;
  assign vbus_pwm_count = q.pwm_cnt;
  assign cnt_run = q.pwm_ctrl[`UEE_PWM_GEN_EN]
                && q.pwm_ctrl[`UEE_PWM_CNT_EN];

  always_comb begin
    rd16  = 16'h0000;
    rd_ok = 1'b1;
    ep_rd = 8'h00;
    if (s_axi_araddr[11:6] == `UEE_EP_PAGE) begin
      ep_rd = ep_view(s_axi_araddr[5:2], q.ep[s_axi_araddr[5:2]],
                      host_role);
      rd16  = {8'h00, ep_rd};
    end else begin
      case (s_axi_araddr)
        `UEE_ADDR_ERR_FLAGS: rd16 = {8'h00, q.err_flags};
        `UEE_ADDR_ERR_EN:    rd16 = {8'h00, q.err_en};
        `UEE_ADDR_PWM_CTRL:  rd16 = q.pwm_ctrl & `UEE_PWM_MASK;
        default:             rd_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    d = q;
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (wr_go) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = 2'b00;
      // low byte lane carries every implemented bit but pwm
      if (wa[11:6] == `UEE_EP_PAGE) begin
        d.ep[wa[5:2]] = wd[7:0] & `UEE_EP_MASK;
      end else begin
        case (wa)
          `UEE_ADDR_ERR_FLAGS:
            d.err_flags = q.err_flags & ~wd[7:0];
          `UEE_ADDR_ERR_EN:
            d.err_en = wd[7:0] & `UEE_ERR_MASK;
          `UEE_ADDR_PWM_CTRL:
            d.pwm_ctrl = wd[15:0] & `UEE_PWM_MASK;
          default: d.bresp = 2'b10;
        endcase
      end
    end
    // hardware set after the clear so a same-cycle event wins
    d.err_flags = (d.err_flags | err_set) & `UEE_ERR_MASK;
    if (ep_stall_event) begin
      d.ep[ep_stall_num][`UEE_EP_STALL] = 1'b1;
    end
    d.summary = |(d.err_flags & q.err_en);
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rdata  = {16'h0000, rd16};
      d.rresp  = rd_ok ? 2'b00 : 2'b10;
    end
    if (cnt_run) begin
      d.pwm_cnt = q.pwm_cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // idle level follows polarity; active level while count below duty
  always_comb begin
    if (!q.pwm_ctrl[`UEE_PWM_GEN_EN]) begin
      vbus_pwm_out = q.pwm_ctrl[`UEE_PWM_POL];
    end else begin
      vbus_pwm_out = (q.pwm_cnt < vbus_pwm_duty)
                   ^ q.pwm_ctrl[`UEE_PWM_POL];
    end
  end
endmodule

// file: rtl/uee_defs.svh
`ifndef UEE_DEFS_SVH
`define UEE_DEFS_SVH
`define UEE_ADDR_ERR_FLAGS  12'h000
`define UEE_ADDR_ERR_EN     12'h004
`define UEE_ADDR_PWM_CTRL   12'h008
`define UEE_ADDR_EP_BASE    12'h040
`define UEE_EP_PAGE         6'h01
`define UEE_ERR_MASK        8'hbf
`define UEE_EP_MASK         8'hdf
`define UEE_EP_HOST0_MASK   8'hc0
`define UEE_PWM_MASK        16'h8300
`define UEE_EP_SETUP_BLK    4
`define UEE_EP_RX_EN        3
`define UEE_EP_TX_EN        2
`define UEE_EP_STALL        1
`define UEE_EP_HSHK         0
`define UEE_EP_LOW_SPEED_DIRECT         7
`define UEE_EP_RETRY_DIS    6
`define UEE_PWM_GEN_EN      15
`define UEE_PWM_POL         9
`define UEE_PWM_CNT_EN      8
`define UEE_RESET_VAL       16'h0000
`endif

// file: rtl/uee_pkg.sv
package uee_pkg;
  typedef enum logic [1:0] {
    UEE_IDLE = 2'b00,
    UEE_WRESP = 2'b01
  } uee_wr_e;
  typedef struct packed {
    logic [7:0]       err_flags;
    logic [7:0]       err_en;
    logic [15:0][7:0] ep;
    logic [15:0]      pwm_ctrl;
    logic [15:0]      pwm_cnt;
    logic             summary;
    logic             bvalid;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [1:0]       bresp;
    logic             aw_got;
    logic             w_got;
    logic [11:0]      awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
  } uee_state_s;
endpackage

// file: tb/uee_ctrl_chk.sv
`timescale 1ns/10ps
module uee_ctrl_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus answers
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // link side
  input wire logic        host_role,
  input wire logic [9:0]  rx_byte_index,
  input wire logic [9:0]  bd_byte_count,
  input wire logic        rx_byte_store,
  input wire logic        tok_rx_allowed,
  input wire logic        tok_tx_allowed,
  input wire logic        tok_setup_allowed,
  input wire logic        low_speed_direct,
  input wire logic        nak_retry_disable,
  input wire logic [15:0] vbus_pwm_count
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write answer dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  a_rdata_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits set");
  a_byte_trunc: assert property (rx_byte_store ==
    (rx_byte_index < bd_byte_count)) else $error("byte store wrong");
  a_low_speed_direct_host: assert property (low_speed_direct |->
    host_role) else $error("low speed outside host");
  a_retry_host: assert property (nak_retry_disable |->
    host_role) else $error("retry disable outside host");
  a_setup_both: assert property (tok_setup_allowed |->
    tok_rx_allowed && tok_tx_allowed) else $error("setup allowed");
  a_count_step: assert property ($changed(vbus_pwm_count) |->
    vbus_pwm_count - $past(vbus_pwm_count) == 16'h0001)
    else $error("counter jumped");
  c_setup: cover property (tok_setup_allowed);
  c_cut: cover property ($fell(rx_byte_store));
  c_low_speed_direct: cover property (low_speed_direct && nak_retry_disable);
endmodule
bind uee_ctrl uee_ctrl_chk i_chk (.*);

// file: tb/uee_ctrl_tb_top.sv
`timescale 1ns/10ps
module uee_ctrl_tb_top;
  typedef struct {logic [11:0] a; logic [31:0] w, e; logic [1:0] r;} uee_row_s;
  logic aclk = 0, aresetn = 0, clk_en = 1, host_role = 0, stall_go = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_arready, s_axi_bvalid, s_axi_rvalid, ep_stall_event;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf, tok_ep = 4'h1, stall_ep = 0, ep_stall_num;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] fire = 0, ev;
  logic ev_stuffing_error, ev_buffer_overrun, ev_turnaround_timeout;
  logic ev_partial_byte, ev_data_checksum_fail, ev_token_checksum_fail;
  logic ev_frame_end_error, ev_packet_id_fail, rx_byte_store;
  logic tok_rx_allowed, tok_tx_allowed, tok_setup_allowed, tok_handshake_en;
  logic low_speed_direct, nak_retry_disable, usb_error_summary_flag;
  logic vbus_pwm_out;
  logic [9:0] rx_byte_index = 0, bd_byte_count = 0;
  logic [15:0] vbus_pwm_count, vbus_pwm_duty = 16'h8000, c;
  int mismatches = 0, tests_run = 0, cycles = 0;
  uee_row_s rows [5] = '{'{12'h004, 32'hffff_ffff, 32'h0000_00bf, 2'h0},
    '{12'h008, 32'hffff_ffff, 32'h0000_8300, 2'h0},
    '{12'h044, 32'hffff_ffff, 32'h0000_001f, 2'h0},
    '{12'h040, 32'hffff_ffff, 32'h0000_001f, 2'h0},
    '{12'h0fc, 32'hffff_ffff, 32'h0000_0000, 2'h2}};
  assign {ev_stuffing_error, ev_frame_end_error, ev_buffer_overrun,
    ev_turnaround_timeout, ev_partial_byte, ev_data_checksum_fail,
    ev_token_checksum_fail, ev_packet_id_fail} = ev;
  uee_ctrl i_dut (.*);
  uee_link_model i_link (.*);
  initial forever #2.5 aclk = ~aclk;
  task automatic chk(input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] w);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(d, e);
  endtask
  task automatic pulse(input logic [7:0] f);
    @(posedge aclk);
    fire <= f;
    @(posedge aclk);
    fire <= 8'h00;
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic print_verdict;
    $display("counts: %0d run, %0d mismatched", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    rst();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk(r, rows[i].r);
      rc(rows[i].a, rows[i].e);
      chk(r, rows[i].r);
    end
    $display("register rows done");
    pulse(8'hbf);
    rc(12'h000, 32'h0000_00bf);
    chk(usb_error_summary_flag, 1'b1);
    wr(12'h000, 32'h0000_000f);
    rc(12'h000, 32'h0000_00b0);
    wr(12'h000, 32'h0000_0000);
    rc(12'h000, 32'h0000_00b0);
    wr(12'h000, 32'h0000_00ff);
    wr(12'h004, 32'h0000_0000);
    pulse(8'h80);
    rc(12'h000, 32'h0000_0080);
    chk(usb_error_summary_flag, 1'b0);
    wr(12'h000, 32'h0000_00ff);
    host_role <= 1'b1;
    pulse(8'h02);
    rc(12'h000, 32'h0000_0000);
    pulse(8'h40);
    rc(12'h000, 32'h0000_0002);
    rc(12'h040, 32'h0000_00df);
    chk({low_speed_direct, nak_retry_disable}, 2'b11);
    $display("error flags done");
    chk({tok_rx_allowed, tok_tx_allowed, tok_setup_allowed}, 3'b110);
    chk(tok_handshake_en, 1'b1);
    wr(12'h044, 32'h0000_000c);
    chk({tok_setup_allowed, tok_handshake_en}, 2'b10);
    wr(12'h044, 32'h0000_0014);
    chk({tok_rx_allowed, tok_tx_allowed}, 2'b01);
    stall_ep <= 4'h2;
    stall_go <= 1'b1;
    @(posedge aclk);
    stall_go <= 1'b0;
    rc(12'h048, 32'h0000_0002);
    wr(12'h008, 32'h0000_0200);
    chk(vbus_pwm_out, 1'b1);
    c = vbus_pwm_count;
    wr(12'h008, 32'h0000_0000);
    chk(vbus_pwm_out, 1'b0);
    chk(vbus_pwm_count, c);
    wr(12'h008, 32'h0000_8100);
    chk(vbus_pwm_out, 1'b1);
    c = vbus_pwm_count;
    repeat (4) @(posedge aclk);
    chk(vbus_pwm_count, c + 16'h0004);
    wr(12'h008, 32'h0000_8300);
    chk(vbus_pwm_out, 1'b0);
    // frozen state: the counter must not move
    clk_en <= 1'b0;
    @(posedge aclk);
    c = vbus_pwm_count;
    repeat (3) @(posedge aclk);
    chk(vbus_pwm_count, c);
    clk_en <= 1'b1;
    wr(12'h004, 32'h0000_00ff);
    rx_byte_index <= 10'h004;
    bd_byte_count <= 10'h005;
    @(posedge aclk);
    chk(rx_byte_store, 1'b1);
    rx_byte_index <= 10'h005;
    @(posedge aclk);
    chk(rx_byte_store, 1'b0);
    $display("endpoint and pwm done");
    rst();
    rc(12'h000, 32'h0000_0000);
    rc(12'h004, 32'h0000_0000);
    rc(12'h008, 32'h0000_0000);
    rc(12'h040, 32'h0000_0000);
    chk(usb_error_summary_flag, 1'b0);
    chk(vbus_pwm_out, 1'b0);
    chk(vbus_pwm_count, 16'h0000);
    $display("reset values done");
    print_verdict();
  end
endmodule

// file: tb/uee_link_model.sv
`timescale 1ns/10ps
module uee_link_model (
  // clock
  input  wire logic       aclk,
  // bench commands
  input  wire logic [7:0] fire,
  input  wire logic       stall_go,
  input  wire logic [3:0] stall_ep,
  // events, bit 6 carries frame end
  output logic      [7:0] ev,
  output logic            ep_stall_event,
  output logic      [3:0] ep_stall_num
);
  always @(posedge aclk) begin
    ev             <= fire;
    ep_stall_event <= stall_go;
    // number is junk outside the pulse
    ep_stall_num   <= stall_ep ^ {4{~stall_go}};
  end
endmodule
